// >>> rtl/eflic_ctrl.sv
// Summary of operation
// RQ1: Select 00: pin released after soft-start, stays high in normal operation.
// RQ2: Loss indicator behaviour: pin pulled low at once on supplement entry.
// RQ3: Select 01: pin low in soft-start, released when storage reaches regulation.
// RQ4: Storage-good behaviour: pin pulled low when storage under 95% of target.
// RQ5: Select 10: pin low in soft-start, released on entering normal operation.
// RQ6: Soft-start is left about 10 ms after the soft-start ramp ends.
// RQ7: Select 11: output-ready first, then loss indicator after first pin rise.
// RQ8: Pin is only pulled low or released, never driven high.
// RQ9: Fuse opens on enable UV/OV, supply OV, fuse OC or drop over 560 mV.
// RQ10: At current limit the output is clamped; further demand opens the fuse.
// RQ11: Soft-start current over 90% of limit: deep shutdown, fuse open, retry.
// RQ12: Fuse re-closes by itself once the fault has cleared.
// RQ13: Soft-start held until drop under 200 mV and the 10 ms timer expired.
// RQ14: Leave power-on state when enable above 0.64 V and supply above lockout.
// RQ15: Leave deep shutdown when temperature has fallen and no over-current.
// RQ16: Combined behaviour keeps loss indication until the next soft-start.
`timescale 1ns/10ps
module eflic_ctrl #(
    parameter int unsigned SS_EXIT_CYC = eflic_pkg::SS_EXIT_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [1:0]            indicator_function_select,
    input  wire logic                  enable_above_uv,
    input  wire logic                  enable_above_ov,
    input  wire logic                  input_supply_ov,
    input  wire logic                  input_supply_above_uvlo,
    input  wire logic                  fuse_over_current,
    input  wire logic                  fuse_at_current_limit,
    input  wire logic                  drop_over_560mv,
    input  wire logic                  drop_under_200mv,
    input  wire logic                  ss_ramp_done,
    input  wire logic                  ss_current_over_90pct,
    input  wire logic                  junction_over_temp,
    input  wire logic                  storage_node_in_reg,
    input  wire logic                  storage_node_under_95pct,
    input  wire logic                  storage_node_depleted,
    input  wire logic                  loss_indicator_pin_i,
    output logic                       loss_indicator_pin_o,
    output logic                       loss_indicator_pin_oe,
    output logic                       fuse_close,
    output logic                       current_clamp,
    output eflic_pkg::eflic_state_t    op_state
);
    import eflic_pkg::*;

    localparam logic [SS_CNT_W-1:0] SS_CNT_MAX = SS_CNT_W'(SS_EXIT_CYC);
    localparam logic [SS_CNT_W-1:0] SS_CNT_ONE = SS_CNT_W'(1);

    eflic_regs_t      r_r;
    eflic_regs_t      r_nxt;
    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] syn;

    logic en_uv_ok;
    logic en_ov;
    logic sup_ov;
    logic sup_ok;
    logic oc;
    logic at_limit;
    logic drop_hi;
    logic drop_lo;
    logic ramp_done;
    logic ss_cur_hi;
    logic hot;
    logic stor_reg;
    logic stor_low;
    logic stor_empty;
    logic pin_level;
    logic fuse_fault;
    logic ss_timer_done;
    logic pin_rise;
    logic release_pin;

    // All pin-side inputs pass the three-stage synchroniser
    always_comb begin
        raw_in                    = '0;
        raw_in[IN_EN_ABOVE_UV]    = enable_above_uv;
        raw_in[IN_EN_ABOVE_OV]    = enable_above_ov;
        raw_in[IN_SUPPLY_OV]      = input_supply_ov;
        raw_in[IN_SUPPLY_UVLO_OK] = input_supply_above_uvlo;
        raw_in[IN_FUSE_OC]        = fuse_over_current;
        raw_in[IN_FUSE_AT_LIMIT]  = fuse_at_current_limit;
        raw_in[IN_DROP_OVER_560]  = drop_over_560mv;
        raw_in[IN_DROP_UNDER_200] = drop_under_200mv;
        raw_in[IN_SS_RAMP_DONE]   = ss_ramp_done;
        raw_in[IN_SS_CUR_OVER_90] = ss_current_over_90pct;
        raw_in[IN_OVER_TEMP]      = junction_over_temp;
        raw_in[IN_STOR_IN_REG]    = storage_node_in_reg;
        raw_in[IN_STOR_UNDER_95]  = storage_node_under_95pct;
        raw_in[IN_STOR_DEPLETED]  = storage_node_depleted;
        raw_in[IN_PIN_LEVEL]      = loss_indicator_pin_i;
    end

    eflic_sync #(
        .WIDTH    (NUM_IN)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (syn)
    );

    assign en_uv_ok   = syn[IN_EN_ABOVE_UV];
    assign en_ov      = syn[IN_EN_ABOVE_OV];
    assign sup_ov     = syn[IN_SUPPLY_OV];
    assign sup_ok     = syn[IN_SUPPLY_UVLO_OK];
    assign oc         = syn[IN_FUSE_OC];
    assign at_limit   = syn[IN_FUSE_AT_LIMIT];
    assign drop_hi    = syn[IN_DROP_OVER_560];
    assign drop_lo    = syn[IN_DROP_UNDER_200];
    assign ramp_done  = syn[IN_SS_RAMP_DONE];
    assign ss_cur_hi  = syn[IN_SS_CUR_OVER_90];
    assign hot        = syn[IN_OVER_TEMP];
    assign stor_reg   = syn[IN_STOR_IN_REG];
    assign stor_low   = syn[IN_STOR_UNDER_95];
    assign stor_empty = syn[IN_STOR_DEPLETED];
    assign pin_level  = syn[IN_PIN_LEVEL];

    // Any of the five fuse-opening conditions
    assign fuse_fault = !en_uv_ok || en_ov || sup_ov || oc || drop_hi; // RQ9

    assign ss_timer_done = (r_r.ss_cnt == SS_CNT_MAX);
    assign pin_rise      = pin_level && !r_r.pin_prev;

    always_comb begin
        r_nxt          = r_r;
        r_nxt.pin_prev = pin_level;
        release_pin    = 1'b0;

        // State sequencing
        case (r_r.st)
            ST_UV_POR: begin
                if (en_uv_ok && sup_ok) begin // RQ14
                    r_nxt.st = ST_SOFT_START;
                end
            end
            ST_SOFT_START: begin
                if (ss_cur_hi) begin
                    r_nxt.st = ST_DEEP_SHUTDOWN; // RQ11
                end else if (fuse_fault) begin
                    r_nxt.st = ST_UV_POR; // RQ9
                end else if (ss_timer_done && drop_lo) begin
                    r_nxt.st = ST_NORMAL; // RQ13
                end
            end
            ST_NORMAL: begin
                if (hot) begin
                    r_nxt.st = ST_DEEP_SHUTDOWN;
                end else if (fuse_fault) begin
                    r_nxt.st = ST_SUPPLEMENT; // RQ9
                end
            end
            ST_SUPPLEMENT: begin
                // Back through power-on once backup runs out or fault clears
                if (stor_empty || !fuse_fault) begin
                    r_nxt.st = ST_UV_POR; // RQ12
                end
            end
            ST_DEEP_SHUTDOWN: begin
                if (!hot && !oc) begin
                    r_nxt.st = ST_SOFT_START; // RQ15
                end
            end
            default: begin
                r_nxt.st = ST_UV_POR;
            end
        endcase

        // Exit timer runs once the ramp has ended, saturates at its limit
        if (r_r.st == ST_SOFT_START && r_nxt.st == ST_SOFT_START) begin
            if (ramp_done && !ss_timer_done) begin
                r_nxt.ss_cnt = r_r.ss_cnt + SS_CNT_ONE; // RQ6
            end
        end else begin
            r_nxt.ss_cnt = '0;
        end

        // Fuse closed only in soft-start and normal operation
        r_nxt.fuse_on = (r_nxt.st == ST_SOFT_START) ||
                        (r_nxt.st == ST_NORMAL); // RQ12
        // Clamp at the limit while the fuse stays closed
        r_nxt.clamp   = r_nxt.fuse_on && at_limit && !oc; // RQ10

        // Output ready: set on leaving soft-start into normal operation
        if (r_nxt.st == ST_UV_POR || r_nxt.st == ST_SOFT_START ||
            r_nxt.st == ST_DEEP_SHUTDOWN) begin
            r_nxt.ready = 1'b0;
        end else if (r_r.st == ST_SOFT_START &&
                     r_nxt.st == ST_NORMAL) begin
            r_nxt.ready = 1'b1; // RQ5
        end

        // Storage good: tracks regulation after soft-start
        if (r_nxt.st == ST_UV_POR || r_nxt.st == ST_SOFT_START ||
            r_nxt.st == ST_DEEP_SHUTDOWN || stor_low) begin
            r_nxt.stor_good = 1'b0; // RQ4
        end else if (stor_reg) begin
            r_nxt.stor_good = 1'b1; // RQ3
        end

        // Combined behaviour hands over on the first pin rise
        if (r_nxt.st == ST_SOFT_START) begin
            r_nxt.handed = 1'b0; // RQ16
        end else if (indicator_function_select == SEL_COMBINED &&
                     r_r.ready && pin_rise) begin
            r_nxt.handed = 1'b1; // RQ7
        end

        // Pin level follows the next state so supplement entry is immediate
        case (indicator_function_select)
            SEL_LOSS_INDICATOR: begin
                release_pin = (r_nxt.st == ST_NORMAL); // RQ1 RQ2
            end
            SEL_STORAGE_GOOD: begin
                release_pin = r_nxt.stor_good; // RQ3 RQ4
            end
            SEL_OUTPUT_READY: begin
                release_pin = r_nxt.ready; // RQ5
            end
            SEL_COMBINED: begin
                if (r_nxt.handed) begin
                    release_pin = (r_nxt.st == ST_NORMAL); // RQ7 RQ2
                end else begin
                    release_pin = r_nxt.ready; // RQ7
                end
            end
            default: begin
                release_pin = 1'b0;
            end
        endcase
        r_nxt.pull_low = !release_pin;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_r <= REGS_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Open-drain: the pad data is always low, only the enable toggles
    assign loss_indicator_pin_o  = 1'b0; // RQ8
    assign loss_indicator_pin_oe = r_r.pull_low; // RQ8
    assign fuse_close            = r_r.fuse_on;
    assign current_clamp         = r_r.clamp;
    assign op_state              = r_r.st;

endmodule : eflic_ctrl

// >>> rtl/eflic_pkg.sv
package eflic_pkg;

    // Operating states, one-hot
    typedef enum logic [4:0] {
        ST_UV_POR        = 5'h01,
        ST_SOFT_START    = 5'h02,
        ST_NORMAL        = 5'h04,
        ST_SUPPLEMENT    = 5'h08,
        ST_DEEP_SHUTDOWN = 5'h10
    } eflic_state_t;

    // Indicator function select codes
    localparam logic [1:0] SEL_LOSS_INDICATOR  = 2'h0;
    localparam logic [1:0] SEL_STORAGE_GOOD    = 2'h1;
    localparam logic [1:0] SEL_OUTPUT_READY    = 2'h2;
    localparam logic [1:0] SEL_COMBINED        = 2'h3;

    // Timebase
    localparam int unsigned REF_CLK_HZ         = 20_000_000;
    localparam int unsigned SS_EXIT_MS         = 10;
    localparam int unsigned SS_EXIT_CYCLES     =
        (REF_CLK_HZ / 1000) * SS_EXIT_MS;
    localparam int unsigned SS_CNT_W           = 18;

    // Positions of the pin-side inputs in the synchroniser vector
    localparam int unsigned IN_EN_ABOVE_UV     = 0;
    localparam int unsigned IN_EN_ABOVE_OV     = 1;
    localparam int unsigned IN_SUPPLY_OV       = 2;
    localparam int unsigned IN_SUPPLY_UVLO_OK  = 3;
    localparam int unsigned IN_FUSE_OC         = 4;
    localparam int unsigned IN_FUSE_AT_LIMIT   = 5;
    localparam int unsigned IN_DROP_OVER_560   = 6;
    localparam int unsigned IN_DROP_UNDER_200  = 7;
    localparam int unsigned IN_SS_RAMP_DONE    = 8;
    localparam int unsigned IN_SS_CUR_OVER_90  = 9;
    localparam int unsigned IN_OVER_TEMP       = 10;
    localparam int unsigned IN_STOR_IN_REG     = 11;
    localparam int unsigned IN_STOR_UNDER_95   = 12;
    localparam int unsigned IN_STOR_DEPLETED   = 13;
    localparam int unsigned IN_PIN_LEVEL       = 14;
    localparam int unsigned NUM_IN             = 15;

    // Register state of the controller
    typedef struct packed {
        eflic_state_t        st;
        logic [SS_CNT_W-1:0] ss_cnt;
        logic                ready;
        logic                stor_good;
        logic                handed;
        logic                pin_prev;
        logic                pull_low;
        logic                fuse_on;
        logic                clamp;
    } eflic_regs_t;

    localparam eflic_regs_t REGS_RESET = '{
        st:        ST_UV_POR,
        ss_cnt:    '0,
        ready:     1'b0,
        stor_good: 1'b0,
        handed:    1'b0,
        pin_prev:  1'b0,
        pull_low:  1'b1,
        fuse_on:   1'b0,
        clamp:     1'b0
    };

endpackage : eflic_pkg

// >>> rtl/eflic_sync.sv
`timescale 1ns/10ps
module eflic_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } eflic_sync_regs_t;

    eflic_sync_regs_t r_r;
    eflic_sync_regs_t r_nxt;
    logic [WIDTH-1:0] q_upd;

    // A change is accepted only once the second and third stages agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign q_upd[i] = (r_r.s2[i] == r_r.s3[i]) ? r_r.s3[i]
                                                       : r_r.q[i];
        end
    endgenerate

    always_comb begin
        r_nxt    = r_r;
        r_nxt.s1 = async_in;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        r_nxt.q  = q_upd;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign sync_out = r_r.q;

endmodule : eflic_sync

// >>> verif/eflic_ctrl_assertions.sv
`timescale 1ns/10ps
module eflic_ctrl_assertions #(
    parameter int unsigned SS_EXIT_CYC = 8
) (
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic [1:0]              indicator_function_select,
    input wire logic                    input_supply_ov,
    input wire logic                    ss_current_over_90pct,
    input wire logic                    loss_indicator_pin_o,
    input wire logic                    loss_indicator_pin_oe,
    input wire logic                    fuse_close,
    input wire logic                    current_clamp,
    input wire eflic_pkg::eflic_state_t op_state
);
    import eflic_pkg::*;
    logic [17:0] ss_len_r;
    always_ff @(posedge ref_clk) begin
        if (rst || op_state != ST_SOFT_START) begin
            ss_len_r <= 18'h0_0000;
        end else begin
            ss_len_r <= ss_len_r + 18'h0_0001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence ss_exit_s;
        op_state == ST_NORMAL && $past(op_state) == ST_SOFT_START;
    endsequence
    sequence ss_over_s;
        (op_state == ST_SOFT_START && ss_current_over_90pct) [*5];
    endsequence
    pin_no_drive_a: assert property (
        !loss_indicator_pin_o) else $error("pin driven high");
    fuse_state_a: assert property (
        fuse_close == (op_state inside {ST_SOFT_START, ST_NORMAL}))
        else $error("fuse state wrong");
    ss_pin_low_a: assert property (
        op_state == ST_SOFT_START |-> loss_indicator_pin_oe)
        else $error("pin released in soft-start");
    ss_exit_time_a: assert property (
        ss_exit_s |-> $past(ss_len_r) >= SS_EXIT_CYC)
        else $error("soft-start left early");
    ready_rise_a: assert property (
        ss_exit_s ##0 $past(indicator_function_select) == SEL_OUTPUT_READY
        |-> !loss_indicator_pin_oe) else $error("ready pin not released");
    loss_normal_a: assert property (
        op_state == ST_NORMAL &&
        $past(indicator_function_select) == SEL_LOSS_INDICATOR
        |-> !loss_indicator_pin_oe) else $error("pin low in normal");
    loss_supp_a: assert property (
        op_state == ST_SUPPLEMENT &&
        $past(indicator_function_select) == SEL_LOSS_INDICATOR
        |-> loss_indicator_pin_oe) else $error("pin high in supplement");
    clamp_fuse_a: assert property (
        current_clamp |-> fuse_close) else $error("clamp with fuse open");
    ss_abort_a: assert property (
        ss_over_s |=> op_state == ST_DEEP_SHUTDOWN)
        else $error("no deep shutdown");
    fault_open_a: assert property (
        (fuse_close && input_supply_ov) [*5] |=> !fuse_close)
        else $error("fuse kept closed");
endmodule : eflic_ctrl_assertions

// >>> verif/eflic_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    checked++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
end
module eflic_ctrl_bench;
    import eflic_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst     = 1'b1;
    logic [1:0]   sel     = 2'h0;
    logic [4:0]   flt     = 5'h00;
    logic         en_ok   = 1'b0;
    logic         ramp    = 1'b0;
    logic         drop_ok = 1'b0;
    logic         ss_hi   = 1'b0;
    logic         hot     = 1'b0;
    logic         at_lim  = 1'b0;
    logic         under95 = 1'b0;
    logic         uvlo_ok = 1'b1;
    logic         in_reg  = 1'b1;
    logic         empty   = 1'b0;
    logic         pin_level;
    logic         pin_o;
    logic         pin_oe;
    logic         fuse_close;
    logic         clamp;
    eflic_state_t op_state;
    int           mismatches = 0;
    int           checked    = 0;
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    eflic_ctrl #(.SS_EXIT_CYC(8)) dut (
        .ref_clk(ref_clk), .rst(rst), .indicator_function_select(sel),
        .enable_above_uv(en_ok & ~flt[0]), .enable_above_ov(flt[1]),
        .input_supply_ov(flt[2]), .input_supply_above_uvlo(uvlo_ok),
        .fuse_over_current(flt[3]), .fuse_at_current_limit(at_lim),
        .drop_over_560mv(flt[4]), .drop_under_200mv(drop_ok),
        .ss_ramp_done(ramp), .ss_current_over_90pct(ss_hi),
        .junction_over_temp(hot), .storage_node_in_reg(in_reg),
        .storage_node_under_95pct(under95), .storage_node_depleted(empty),
        .loss_indicator_pin_i(pin_level), .loss_indicator_pin_o(pin_o),
        .loss_indicator_pin_oe(pin_oe), .fuse_close(fuse_close),
        .current_clamp(clamp), .op_state(op_state));
    eflic_host_model host (
        .pin_pull(pin_oe), .pin_out(pin_o), .pin_level(pin_level));
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_st(input eflic_state_t s);
        int n;
        n = 0;
        while (op_state !== s && n < 200) begin
            step(1);
            n++;
        end
        `CHK("op_state", s, op_state)
        if (op_state !== s) report_and_stop();
    endtask : wait_st
    task automatic power_up(input logic [1:0] s);
        sel = s; ramp = 1'b0; drop_ok = 1'b1; en_ok = 1'b1; flt = 5'h00;
        wait_st(ST_SOFT_START);
        step(20);
        `CHK("ss timer", ST_SOFT_START, op_state)
        `CHK("ss pin", 1'b1, pin_oe)
        ramp = 1'b1; drop_ok = 1'b0; step(20);
        `CHK("ss drop", ST_SOFT_START, op_state)
        drop_ok = 1'b1;
        wait_st(ST_NORMAL);
        step(8);
        `CHK("fuse closed", 1'b1, fuse_close)
        `CHK("normal pin", 1'b0, pin_oe)
    endtask : power_up
    task automatic sc_loop;
        for (int i = 0; i < 5; i++) begin
            power_up(i[1:0]);
            if (i == 1) begin
                under95 = 1'b1; step(8);
                `CHK("storage low", 1'b1, pin_oe)
                in_reg = 1'b0; under95 = 1'b0; step(8);
                `CHK("storage unreg", 1'b1, pin_oe)
                in_reg = 1'b1; step(8);
                `CHK("storage reg", 1'b0, pin_oe)
            end
            flt = 5'h01 << i;
            wait_st(ST_SUPPLEMENT);
            `CHK("fuse open", 1'b0, fuse_close)
            `CHK("supp pin", i != 1 && i != 2, pin_oe)
        end
    endtask : sc_loop
    task automatic sc_clamp;
        power_up(2'h0);
        at_lim = 1'b1; step(8);
        `CHK("clamp on", 1'b1, clamp)
        flt = 5'h08;
        wait_st(ST_SUPPLEMENT);
        `CHK("clamp fuse", 1'b0, fuse_close)
        // Backup exhausted while the fault persists: back to power-on
        empty = 1'b1; en_ok = 1'b0;
        wait_st(ST_UV_POR);
        empty = 1'b0;
        at_lim = 1'b0;
    endtask : sc_clamp
    task automatic sc_deep;
        flt = 5'h00; ramp = 1'b0; hot = 1'b1; en_ok = 1'b1;
        wait_st(ST_SOFT_START);
        ss_hi = 1'b1;
        wait_st(ST_DEEP_SHUTDOWN);
        `CHK("deep fuse", 1'b0, fuse_close)
        ss_hi = 1'b0; step(10);
        `CHK("deep hold", ST_DEEP_SHUTDOWN, op_state)
        hot = 1'b0;
        wait_st(ST_SOFT_START);
    endtask : sc_deep
    initial begin
        step(8);
        rst = 1'b0;
        step(10);
        `CHK("por hold", ST_UV_POR, op_state)
        en_ok = 1'b1; uvlo_ok = 1'b0; step(10);
        `CHK("uvlo hold", ST_UV_POR, op_state)
        uvlo_ok = 1'b1;
        sc_loop();
        sc_clamp();
        sc_deep();
        report_and_stop();
    end
endmodule : eflic_ctrl_bench
bind eflic_ctrl eflic_ctrl_assertions #(.SS_EXIT_CYC(SS_EXIT_CYC)) chk (
    .ref_clk(ref_clk), .rst(rst),
    .indicator_function_select(indicator_function_select),
    .input_supply_ov(input_supply_ov),
    .ss_current_over_90pct(ss_current_over_90pct),
    .loss_indicator_pin_o(loss_indicator_pin_o),
    .loss_indicator_pin_oe(loss_indicator_pin_oe),
    .fuse_close(fuse_close), .current_clamp(current_clamp),
    .op_state(op_state));

// >>> verif/eflic_host_model.sv
`timescale 1ns/10ps
module eflic_host_model (
    input  wire logic pin_pull,
    input  wire logic pin_out,
    output logic      pin_level
);
    // External pull-up sets the high level
    assign pin_level = pin_pull ? pin_out : 1'b1;
endmodule : eflic_host_model
